// [cpu_decode_pkg.sv]
/*
 * Constants, opcode patterns, register map and state types for the
 * control-transfer, inherent and pointer instruction decoder.
 * Assumes a single core clock; one instruction cycle per clock.
 */
package cpu_decode_pkg;
   // ********************************************
   // Sizes
   // ********************************************
   localparam int DMEM_DEPTH = 128;
   localparam int STACK_DEPTH = 16;
   localparam int DIR_COUNT = 8;
   localparam int APB_AW = 12;
   // ********************************************
   // Register byte offsets
   // ********************************************
   localparam logic [11:0] ADDR_INSTR = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam logic [11:0] ADDR_WREG = 12'h008;
   localparam logic [11:0] ADDR_PTR0 = 12'h00c;
   localparam logic [11:0] ADDR_PTR1 = 12'h010;
   localparam logic [11:0] ADDR_PC = 12'h014;
   localparam logic [11:0] ADDR_OPTION = 12'h018;
   localparam logic [11:0] ADDR_DIR_BASE = 12'h040;
   localparam logic [11:0] ADDR_DMEM_BASE = 12'h200;
   // ********************************************
   // Fixed instruction words
   // ********************************************
   localparam logic [13:0] OP_NOP = 14'h0000;
   localparam logic [13:0] OP_SWRESET = 14'h0001;
   localparam logic [13:0] OP_RETURN = 14'h0008;
   localparam logic [13:0] OP_INTERRUPT_RETURN_OP = 14'h0009;
   localparam logic [13:0] OP_SUBROUTINE_JUMP_WREG_OP = 14'h000a;
   localparam logic [13:0] OP_BRW = 14'h000b;
   localparam logic [13:0] OP_OPTION = 14'h0062;
   localparam logic [13:0] OP_STANDBY = 14'h0063;
   localparam logic [13:0] OP_WATCHDOG_CLEAR_OP = 14'h0064;
   // ********************************************
   // Opcode prefixes, compared on the top bits
   // ********************************************
   localparam logic [4:0] PFX_REL_BRANCH = 5'h19;
   localparam logic [2:0] PFX_CALL = 3'h4;
   localparam logic [2:0] PFX_ABSOLUTE_JUMP_OP = 3'h5;
   localparam logic [5:0] PFX_LIT_RETURN = 6'h34;
   localparam logic [10:0] PFX_DIR_LOAD = 11'h00c;
   localparam logic [6:0] PFX_PTR_ADD = 7'h62;
   localparam logic [10:0] PFX_IND_READ = 11'h002;
   localparam logic [10:0] PFX_IND_WRITE = 11'h003;
   localparam logic [6:0] PFX_IDX_READ = 7'h7e;
   localparam logic [6:0] PFX_IDX_WRITE = 7'h7f;
   localparam logic [5:0] PFX_LIT_ADD = 6'h3e;
   localparam logic [5:0] PFX_LIT_AND = 6'h39;
   localparam logic [5:0] PFX_REG_AND = 6'h05;
   // File addresses that alias the indirect data registers
   localparam logic [6:0] FILE_IND0 = 7'h00;
   localparam logic [6:0] FILE_IND1 = 7'h01;
   // Pointer modifier codes
   localparam logic [1:0] MOD_PRE_INC = 2'h0;
   localparam logic [1:0] MOD_PRE_DEC = 2'h1;
   localparam logic [1:0] MOD_POST_INC = 2'h2;
   // Cycle counts
   localparam logic [1:0] CYC_ONE = 2'h1;
   localparam logic [1:0] CYC_TWO = 2'h2;
   // Status register bit positions
   localparam int ST_BUSY = 0;
   localparam int ST_C = 1;
   localparam int ST_DC = 2;
   localparam int ST_Z = 3;
   localparam int ST_TO = 4;
   localparam int ST_PD = 5;
   localparam int ST_GIE = 6;
   localparam int ST_ILLEGAL = 7;
   localparam int ST_CYC_LSB = 8;

   typedef enum logic [1:0] {S_IDLE, S_EXEC, S_WAIT} exec_state_e;

   typedef struct packed {
      exec_state_e st;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic [13:0] instr;
      logic [7:0] wreg;
      logic c;
      logic dc;
      logic z;
      logic timeout_flag;
      logic powerdown_flag;
      logic gie;
      logic illegal;
      logic [15:0] ptr0;
      logic [15:0] ptr1;
      logic [14:0] pc;
      logic [3:0] sp;
      logic [STACK_DEPTH-1:0][14:0] stack;
      logic [7:0] option;
      logic [DIR_COUNT-1:0][7:0] dir;
      logic [DMEM_DEPTH-1:0][7:0] dmem;
      logic [1:0] left;
      logic [1:0] last_cyc;
      logic wdt_clr;
      logic standby;
      logic swrst;
   } core_s;
endpackage

// [cpu_control_and_fsr_op_decoder.sv]
/*
 * Decoder and executor for control transfers, inherent operations,
 * pointer-pair operations and three literal/register logic forms.
 * Software writes one instruction word over APB and the core runs it.
 * Assumes APB master and inputs synchronous to core_clk_i.
 */
// Summary of operation
// - PC change by branch, jump, call or return costs two cycles
// - Indirect access, effective address MSb set adds cycle
// - Decode relative branch and W-relative branch
// - Decode call, jump, call through W
// - Decode return and interrupt return, pop stack
// - Literal return loads W, two cycles
// - Watchdog clear sets timeout and powerdown flags
// - Standby entry updates timeout and powerdown flags
// - Software reset pulse; all-zero word is no-op
// - Option register loads from W
// - Direction register selected by three bits
// - Pointer add decode, one cycle
// - Pointer add signed, 16-bit wrap, flags kept
// - Indirect read with modifier sets zero flag
// - Indirect write with modifier, flags kept
// - Indexed indirect read sets zero flag
// - Indexed indirect write, flags kept
// - Literal add updates carry, digit carry, zero
// - Literal AND updates zero only
// - Register AND to W or f, zero only
// - Branch target is next address plus offset
`timescale 1ns/1ps
module cpu_control_and_fsr_op_decoder
   import cpu_decode_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [APB_AW-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   output logic wdt_clear_o,
   output logic standby_o,
   output logic sw_reset_o
);
   core_s s_q;
   core_s s_d;

   // ********************************************
   // Next state
   // ********************************************
   always_comb begin
      logic [13:0] ins;
      logic [15:0] ptr;
      logic [15:0] ptr_new;
      logic [15:0] ea;
      logic [8:0] sum;
      logic [4:0] hsum;
      logic [7:0] rdv;
      logic [7:0] andv;
      logic [14:0] nxt;
      logic sel;
      logic two;
      logic extra;
      logic wr_ok;
      logic ind;
      ins = s_q.instr;
      ptr = '0;
      ptr_new = '0;
      ea = '0;
      sum = '0;
      hsum = '0;
      rdv = '0;
      andv = '0;
      nxt = s_q.pc + 15'h1;
      sel = 1'b0;
      two = 1'b0;
      extra = 1'b0;
      ind = 1'b0;
      wr_ok = 1'b0;
      s_d = s_q;
      // Ready and error both stand for the access cycle only
      s_d.pready = 1'b0;
      s_d.pslverr = 1'b0;
      s_d.wdt_clr = 1'b0;
      s_d.standby = 1'b0;
      s_d.swrst = 1'b0;

      // ********************************************
      // APB setup: answer in the following access cycle
      // ********************************************
      if (psel_i && !penable_i) begin
         s_d.pready = 1'b1;
         s_d.pslverr = 1'b0;
         s_d.prdata = '0;
         // Writes while an instruction runs would race the executor
         if (pwrite_i && s_q.st != S_IDLE) begin
            s_d.pslverr = 1'b1;
         end else if (paddr_i == ADDR_INSTR) begin
            s_d.prdata = {18'h0, s_q.instr};
         end else if (paddr_i == ADDR_STATUS) begin
            s_d.prdata[ST_BUSY] = (s_q.st != S_IDLE);
            s_d.prdata[ST_C] = s_q.c;
            s_d.prdata[ST_DC] = s_q.dc;
            s_d.prdata[ST_Z] = s_q.z;
            s_d.prdata[ST_TO] = s_q.timeout_flag;
            s_d.prdata[ST_PD] = s_q.powerdown_flag;
            s_d.prdata[ST_GIE] = s_q.gie;
            s_d.prdata[ST_ILLEGAL] = s_q.illegal;
            s_d.prdata[ST_CYC_LSB +: 2] = s_q.last_cyc;
         end else if (paddr_i == ADDR_WREG) begin
            s_d.prdata = {24'h0, s_q.wreg};
         end else if (paddr_i == ADDR_PTR0) begin
            s_d.prdata = {16'h0, s_q.ptr0};
         end else if (paddr_i == ADDR_PTR1) begin
            s_d.prdata = {16'h0, s_q.ptr1};
         end else if (paddr_i == ADDR_PC) begin
            s_d.prdata = {17'h0, s_q.pc};
         end else if (paddr_i == ADDR_OPTION) begin
            s_d.prdata = {24'h0, s_q.option};
         end else if (paddr_i[11:5] == ADDR_DIR_BASE[11:5]) begin
            s_d.prdata = {24'h0, s_q.dir[paddr_i[4:2]]};
         end else if (paddr_i[11:9] == ADDR_DMEM_BASE[11:9]) begin
            s_d.prdata = {24'h0, s_q.dmem[paddr_i[8:2]]};
         end else begin
            s_d.pslverr = 1'b1;
         end
      end

      // Write acts only at the edge that completes the access
      wr_ok = psel_i && penable_i && pwrite_i && s_q.pready
         && !s_q.pslverr;
      if (wr_ok) begin
         if (paddr_i == ADDR_INSTR) begin
            s_d.instr = pwdata_i[13:0];
            s_d.st = S_EXEC;
         end else if (paddr_i == ADDR_STATUS) begin
            s_d.c = pwdata_i[ST_C];
            s_d.dc = pwdata_i[ST_DC];
            s_d.z = pwdata_i[ST_Z];
            s_d.gie = pwdata_i[ST_GIE];
            s_d.illegal = 1'b0;
         end else if (paddr_i == ADDR_WREG) begin
            s_d.wreg = pwdata_i[7:0];
         end else if (paddr_i == ADDR_PTR0) begin
            s_d.ptr0 = pwdata_i[15:0];
         end else if (paddr_i == ADDR_PTR1) begin
            s_d.ptr1 = pwdata_i[15:0];
         end else if (paddr_i == ADDR_PC) begin
            s_d.pc = pwdata_i[14:0];
         end else if (paddr_i[11:9] == ADDR_DMEM_BASE[11:9]) begin
            s_d.dmem[paddr_i[8:2]] = pwdata_i[7:0];
         end
      end

      // ********************************************
      // Execute
      // ********************************************
      case (s_q.st)
         S_EXEC: begin
            s_d.pc = nxt;
            if (ins == OP_NOP) begin
            end else if (ins == OP_SWRESET) begin
               s_d.swrst = 1'b1;
               s_d.pc = '0;
               s_d.sp = '0;
               s_d.wreg = '0;
               s_d.ptr0 = '0;
               s_d.ptr1 = '0;
            end else if (ins == OP_BRW) begin
               s_d.pc = nxt + {7'h0, s_q.wreg};
               two = 1'b1;
            end else if (ins == OP_SUBROUTINE_JUMP_WREG_OP) begin
               s_d.stack[s_q.sp] = nxt;
               s_d.sp = s_q.sp + 4'h1;
               s_d.pc = {s_q.pc[14:8], s_q.wreg};
               two = 1'b1;
            end else if (ins == OP_RETURN || ins == OP_INTERRUPT_RETURN_OP) begin
               s_d.sp = s_q.sp - 4'h1;
               s_d.pc = s_q.stack[s_d.sp];
               if (ins == OP_INTERRUPT_RETURN_OP) begin
                  s_d.gie = 1'b1;
               end
               two = 1'b1;
            end else if (ins == OP_WATCHDOG_CLEAR_OP) begin
               s_d.timeout_flag = 1'b1;
               s_d.powerdown_flag = 1'b1;
               s_d.wdt_clr = 1'b1;
            end else if (ins == OP_STANDBY) begin
               // Standby also restarts the watchdog
               s_d.timeout_flag = 1'b1;
               s_d.powerdown_flag = 1'b0;
               s_d.wdt_clr = 1'b1;
               s_d.standby = 1'b1;
            end else if (ins == OP_OPTION) begin
               s_d.option = s_q.wreg;
            end else if (ins[13:3] == PFX_DIR_LOAD) begin
               // Fixed words above take priority over this pattern
               s_d.dir[ins[2:0]] = s_q.wreg;
            end else if (ins[13:9] == PFX_REL_BRANCH) begin
               s_d.pc = nxt + {{6{ins[8]}}, ins[8:0]};
               two = 1'b1;
            end else if (ins[13:11] == PFX_CALL) begin
               s_d.stack[s_q.sp] = nxt;
               s_d.sp = s_q.sp + 4'h1;
               s_d.pc = {s_q.pc[14:11], ins[10:0]};
               two = 1'b1;
            end else if (ins[13:11] == PFX_ABSOLUTE_JUMP_OP) begin
               s_d.pc = {s_q.pc[14:11], ins[10:0]};
               two = 1'b1;
            end else if (ins[13:8] == PFX_LIT_RETURN) begin
               s_d.wreg = ins[7:0];
               s_d.sp = s_q.sp - 4'h1;
               s_d.pc = s_q.stack[s_d.sp];
               two = 1'b1;
            end else if (ins[13:7] == PFX_PTR_ADD) begin
               ptr = ins[6] ? s_q.ptr1 : s_q.ptr0;
               ptr_new = ptr + {{10{ins[5]}}, ins[5:0]};
               if (ins[6]) begin
                  s_d.ptr1 = ptr_new;
               end else begin
                  s_d.ptr0 = ptr_new;
               end
            end else if (ins[13:3] == PFX_IND_READ
                  || ins[13:3] == PFX_IND_WRITE) begin
               ptr = ins[2] ? s_q.ptr1 : s_q.ptr0;
               ptr_new = ins[0] ? ptr - 16'h1 : ptr + 16'h1;
               ea = (ins[1:0] == MOD_PRE_INC
                  || ins[1:0] == MOD_PRE_DEC) ? ptr_new : ptr;
               if (ins[2]) begin
                  s_d.ptr1 = ptr_new;
               end else begin
                  s_d.ptr0 = ptr_new;
               end
               ind = 1'b1;
               if (ins[3]) begin
                  s_d.dmem[ea[6:0]] = s_q.wreg;
               end else begin
                  s_d.wreg = s_q.dmem[ea[6:0]];
                  s_d.z = (s_d.wreg == 8'h00);
               end
            end else if (ins[13:7] == PFX_IDX_READ
                  || ins[13:7] == PFX_IDX_WRITE) begin
               ptr = ins[6] ? s_q.ptr1 : s_q.ptr0;
               ea = ptr + {{10{ins[5]}}, ins[5:0]};
               ind = 1'b1;
               if (ins[7]) begin
                  s_d.dmem[ea[6:0]] = s_q.wreg;
               end else begin
                  s_d.wreg = s_q.dmem[ea[6:0]];
                  s_d.z = (s_d.wreg == 8'h00);
               end
            end else if (ins[13:8] == PFX_LIT_ADD) begin
               sum = {1'b0, s_q.wreg} + {1'b0, ins[7:0]};
               hsum = {1'b0, s_q.wreg[3:0]} + {1'b0, ins[3:0]};
               s_d.wreg = sum[7:0];
               s_d.c = sum[8];
               s_d.dc = hsum[4];
               s_d.z = (sum[7:0] == 8'h00);
            end else if (ins[13:8] == PFX_LIT_AND) begin
               s_d.wreg = s_q.wreg & ins[7:0];
               s_d.z = (s_d.wreg == 8'h00);
            end else if (ins[13:8] == PFX_REG_AND) begin
               // File 0/1 alias the indirect data registers
               sel = (ins[6:0] == FILE_IND1);
               ind = (ins[6:0] == FILE_IND0) || sel;
               ptr = sel ? s_q.ptr1 : s_q.ptr0;
               ea = ind ? ptr : {9'h0, ins[6:0]};
               rdv = s_q.dmem[ea[6:0]];
               andv = s_q.wreg & rdv;
               if (ins[7]) begin
                  s_d.dmem[ea[6:0]] = andv;
               end else begin
                  s_d.wreg = andv;
               end
               s_d.z = (andv == 8'h00);
            end else begin
               // Unknown words run as a one-cycle no-op that sets the illegal flag
               s_d.illegal = 1'b1;
            end
            extra = ind && ea[15];
            s_d.last_cyc = (two ? CYC_TWO : CYC_ONE)
               + {1'b0, extra};
            s_d.left = s_d.last_cyc - CYC_ONE;
            s_d.st = (s_d.left == 2'h0) ? S_IDLE : S_WAIT;
         end
         S_WAIT: begin
            // Idle no-op cycles after the executing one
            s_d.left = s_q.left - 2'h1;
            if (s_q.left == CYC_ONE) begin
               s_d.st = S_IDLE;
            end
         end
         default: begin
         end
      endcase
   end

   // ********************************************
   // State register
   // ********************************************
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_q <= '0;
         s_q.timeout_flag <= 1'b1;
         s_q.powerdown_flag <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata_o = s_q.prdata;
   assign pready_o = s_q.pready;
   assign pslverr_o = s_q.pslverr;
   assign wdt_clear_o = s_q.wdt_clr;
   assign standby_o = s_q.standby;
   assign sw_reset_o = s_q.swrst;
endmodule

// [prog_mem.sv]
/* Program memory model: ten control-transfer words for the bench.
   Assumes the bench selects a word by index and lets a clock pass. */
`timescale 1ns/1ps
module prog_mem (
   input wire logic [3:0] idx_i,
   output logic [13:0] word_o
);
   // Branches, jump, calls and the three return forms
   localparam logic [13:0] rom_words [10] = '{14'h3300, 14'h32ff,
      14'h2fff, 14'h2123, 14'h3455, 14'h000a, 14'h0008, 14'h000b,
      14'h2010, 14'h0009};
   // Past the table a no-op, never a stale word
   assign word_o = (idx_i < 4'ha) ? rom_words[idx_i] : 14'h0000;
endmodule

// [decoder_chk.sv]
/* Checker for the decoder: APB answer timing and the pulse outputs.
   Assumes it sees only the top module's ports, bound below. */
`timescale 1ns/1ps
module decoder_chk
   import cpu_decode_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [APB_AW-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_i,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic wdt_clear_o,
   input wire logic standby_o,
   input wire logic sw_reset_o
);
   logic instr_wr;
   // Accepted instruction write, seen in its access cycle
   assign instr_wr = pready_o && psel_i && penable_i && pwrite_i &&
      !pslverr_o && paddr_i[11:2] == 10'h0;
   default clocking @(posedge core_clk_i);
   endclocking
   default disable iff (!reset_n_i);
   setup_ready_a: assert property (psel_i && !penable_i |=> pready_o)
      else $error("no ready after setup");
   ready_cause_a: assert property (pready_o |-> $past(psel_i && !penable_i))
      else $error("ready without setup");
   err_ready_a: assert property (pslverr_o |-> pready_o)
      else $error("error outside access");
   clear_pulse_a: assert property (
      instr_wr && pwdata_i[13:0] == OP_WATCHDOG_CLEAR_OP |=> ##1 wdt_clear_o ##1
      !wdt_clear_o) else $error("watchdog clear pulse wrong");
   standby_pair_a: assert property (
      instr_wr && pwdata_i[13:0] == OP_STANDBY |=> ##1 standby_o &&
      wdt_clear_o) else $error("standby pulses wrong");
   standby_cause_a: assert property (
      standby_o |-> $past(pwdata_i[13:0], 2) == OP_STANDBY)
      else $error("standby without its word");
   reset_pulse_a: assert property (
      instr_wr && pwdata_i[13:0] == OP_SWRESET |=> ##1 sw_reset_o ##1
      !sw_reset_o) else $error("software reset pulse wrong");
   nop_quiet_a: assert property (
      instr_wr && pwdata_i[13:0] == OP_NOP |=> ##1
      !(wdt_clear_o || standby_o || sw_reset_o))
      else $error("no-op raised a pulse");
   reset_cause_a: assert property (sw_reset_o |-> $past(instr_wr, 2))
      else $error("software reset without write");
endmodule
bind cpu_control_and_fsr_op_decoder decoder_chk chk_i (
   .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .pwdata_i(pwdata_i), .prdata_i(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .wdt_clear_o(wdt_clear_o),
   .standby_o(standby_o), .sw_reset_o(sw_reset_o));

// [cpu_control_and_fsr_op_decoder_tb.sv]
/* Self-checking bench: runs instruction words over APB and compares.
   Assumes the checker is bound and prog_mem holds control words. */
`timescale 1ns/1ps
module cpu_control_and_fsr_op_decoder_tb
   import cpu_decode_pkg::*;
;
   logic clk, rst_n, psel, penable, pwrite, err;
   logic pready, pslverr, wdt, stby, swr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic [3:0] ri;
   logic [13:0] rw;
   int n_fail, checks_done, n_wdt, n_stb, n_swr;
   cpu_control_and_fsr_op_decoder uut (.core_clk_i(clk),
      .reset_n_i(rst_n), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .wdt_clear_o(wdt), .standby_o(stby), .sw_reset_o(swr));
   prog_mem pm (.idx_i(ri), .word_o(rw));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (wdt === 1'b1) n_wdt++;
      if (stby === 1'b1) n_stb++;
      if (swr === 1'b1) n_swr++;
   end
   task automatic chk(input string nm, input logic [31:0] e,
         input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask
   // Idle edge first, so back-to-back calls never drive psel twice
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // No assumed wait count; the watchdog ends a hang
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rdv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rc(input string nm, input logic [11:0] a,
         input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rdv);
   endtask
   task automatic wait_done();
      do begin
         apb(1'b0, ADDR_STATUS, 32'h0);
      end while (rdv[0] !== 1'b0);
   endtask
   task automatic run(input logic [13:0] op, input logic [1:0] cyc);
      wr(ADDR_INSTR, 32'(op));
      wait_done();
      chk("cycles", 32'(cyc), 32'(rdv[9:8]));
   endtask
   task automatic t_reset();
      rc("status", ADDR_STATUS, 32'h030);
      rc("pc", ADDR_PC, 32'h0);
      apb(1'b0, 12'h01c, 32'h0);
      chk("err", 32'h1, 32'(err));
      chk("rdata", 32'h0, rdv);
   endtask
   task automatic t_alu();
      wr(ADDR_WREG, 32'h0f);
      run(14'h3e01, CYC_ONE);
      chk("status", 32'h134, rdv);
      run(14'h3ef0, CYC_ONE);
      chk("status", 32'h13a, rdv);
      rc("w", ADDR_WREG, 32'h00);
      wr(ADDR_WREG, 32'h3c);
      run(14'h390f, CYC_ONE);
      chk("status", 32'h132, rdv);
      rc("w", ADDR_WREG, 32'h0c);
      wr(ADDR_DMEM_BASE + 12'h014, 32'hf0);
      run(14'h0505, CYC_ONE);
      chk("status", 32'h13a, rdv);
      rc("w", ADDR_WREG, 32'h00);
      wr(ADDR_WREG, 32'h3c);
      run(14'h0585, CYC_ONE);
      chk("status", 32'h132, rdv);
      rc("f", ADDR_DMEM_BASE + 12'h014, 32'h30);
   endtask
   task automatic t_ptr();
      wr(ADDR_PTR0, 32'hffff);
      run(14'h3101, CYC_ONE);
      chk("status", 32'h132, rdv);
      rc("ptr0", ADDR_PTR0, 32'h0000);
      run(14'h3120, CYC_ONE);
      rc("ptr0", ADDR_PTR0, 32'hffe0);
      run(14'h315f, CYC_ONE);
      rc("ptr1", ADDR_PTR1, 32'h001f);
   endtask
   task automatic t_ind();
      logic [13:0] ops [4] = '{14'h001e, 14'h001c, 14'h0017, 14'h0015};
      logic [15:0] ps [4] = '{16'h11, 16'h12, 16'h11, 16'h10};
      wr(ADDR_PTR1, 32'h10);
      wr(ADDR_WREG, 32'ha5);
      for (int i = 0; i < 4; i++) begin
         if (i > 1) wr(ADDR_WREG, 32'h0);
         run(ops[i], CYC_ONE);
         chk("status", 32'h132, rdv);
         rc("ptr1", ADDR_PTR1, 32'(ps[i]));
         rc("w", ADDR_WREG, 32'ha5);
      end
      rc("mem", ADDR_DMEM_BASE + 12'h048, 32'ha5);
      wr(ADDR_WREG, 32'h3c);
      run(14'h3ffe, CYC_ONE);
      rc("mem", ADDR_DMEM_BASE + 12'h038, 32'h3c);
      wr(ADDR_WREG, 32'h0);
      run(14'h3f7e, CYC_ONE);
      rc("w", ADDR_WREG, 32'h3c);
      wr(ADDR_PTR0, 32'h8003);
      run(14'h001a, CYC_TWO);
      rc("mem", ADDR_DMEM_BASE + 12'h00c, 32'h3c);
   endtask
   task automatic t_ctl();
      logic [14:0] pcs [10] = '{15'h001, 15'h101, 15'h7ff, 15'h123,
         15'h800, 15'h855, 15'h801, 15'h857, 15'h810, 15'h858};
      wr(ADDR_PC, 32'h100);
      for (int i = 0; i < 10; i++) begin
         ri <= 4'(i);
         @(posedge clk);
         run(rw, CYC_TWO);
         rc("pc", ADDR_PC, 32'(pcs[i]));
      end
      rc("w", ADDR_WREG, 32'h55);
      rc("status", ADDR_STATUS, 32'h272);
   endtask
   task automatic t_inh();
      run(OP_WATCHDOG_CLEAR_OP, CYC_ONE);
      chk("to_pd", 32'h3, 32'(rdv[5:4]));
      run(OP_STANDBY, CYC_ONE);
      chk("to_pd", 32'h1, 32'(rdv[5:4]));
      run(OP_WATCHDOG_CLEAR_OP, CYC_ONE);
      chk("to_pd", 32'h3, 32'(rdv[5:4]));
      chk("wdt", 32'h3, 32'(n_wdt));
      chk("stby", 32'h1, 32'(n_stb));
      wr(ADDR_WREG, 32'h77);
      run(OP_OPTION, CYC_ONE);
      rc("option", ADDR_OPTION, 32'h77);
      for (int f = 0; f < 8; f++) begin
         if (f > 1 && f < 5) continue;
         wr(ADDR_WREG, 32'h40 + 32'(f));
         run(14'h0060 | 14'(f), CYC_ONE);
         rc("dir", ADDR_DIR_BASE + 12'(4 * f), 32'h40 + 32'(f));
      end
      run(OP_NOP, CYC_ONE);
      rc("w", ADDR_WREG, 32'h47);
      run(OP_SWRESET, CYC_ONE);
      chk("swr", 32'h1, 32'(n_swr));
      rc("pc", ADDR_PC, 32'h0);
   endtask
   // Second write lands while the jump still holds the core busy
   task automatic t_busy();
      wr(ADDR_WREG, 32'h01);
      wr(ADDR_INSTR, 32'h2805);
      wr(ADDR_INSTR, 32'h3e01);
      chk("busy_err", 32'h1, 32'(err));
      wait_done();
      rc("w", ADDR_WREG, 32'h01);
      rc("pc", ADDR_PC, 32'h005);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      end_of_test();
   end
   initial begin
      {rst_n, psel, penable, pwrite, paddr, pwdata, ri} <= '0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_alu();
      t_ptr();
      t_ind();
      t_ctl();
      t_inh();
      t_busy();
      end_of_test();
   end
endmodule
